//--- hw/ssc_consts.svh
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// Clock rate and master serial bus speeds, in their own units.
`define SSC_PCLK_KHZ        250000
`define SSC_SMB_FAST_KHZ    400
`define SSC_SMB_SLOW_KHZ    100
// Half period in pclk cycles, rounded up so the bus never runs too fast.
`define SSC_HALF_CNT(khz)   ((`SSC_PCLK_KHZ + 2 * (khz) - 1) / (2 * (khz)))

// Reference clock choices and the PLL feedback divider for each.
`define SSC_REF_LO_MHZ      100
`define SSC_REF_HI_MHZ      125
`define SSC_PLL_VCO_MHZ     2500
`define SSC_PLL_DIV_LO      8'(`SSC_PLL_VCO_MHZ / `SSC_REF_LO_MHZ)
`define SSC_PLL_DIV_HI      8'(`SSC_PLL_VCO_MHZ / `SSC_REF_HI_MHZ)

// Fixed address bits around the strapped ones.
`define SSC_EE_ADDR_BASE    7'h50
`define SSC_SLV_ADDR_BASE   7'h40
// Clocking mode codes whose ports take their own reference clock.
`define SSC_LOCAL_MODE_SET  8'hF0

// Port geometry.
`define SSC_PAIRS           8
`define SSC_PORTS           16
`define SSC_LANE_BITS       4
`define SSC_LANES_X8        4'h8
`define SSC_LANES_X4        4'h4
`define SSC_LANES_NONE      4'h0

// Pin function selection.
`define SSC_GPIO_COUNT      54
`define SSC_WORD_BITS       32
`define SSC_EN_WORDS        2
`define SSC_GPIO_WORDS      6
`define SSC_EN_TOP_BITS     (`SSC_GPIO_COUNT - `SSC_WORD_BITS)
`define SSC_SEL_TOP_BITS    (2 * `SSC_GPIO_COUNT - 3 * `SSC_WORD_BITS)

// Register byte offsets.
`define SSC_OFF_STATUS      12'h000
`define SSC_OFF_ADDRS       12'h004
`define SSC_OFF_PORTS       12'h008
`define SSC_OFF_GPIO        12'h010
`define SSC_OFF_GPIO_END    12'h028

// Field positions.
`define SSC_ST_VALID        0
`define SSC_ST_REF_HI       1
`define SSC_ST_SLOW         2
`define SSC_ST_MODE         4
`define SSC_ST_MERGED       8
`define SSC_AD_EE           0
`define SSC_AD_SLV          8
`define SSC_PT_LOCAL        0
`define SSC_PT_ENABLED      16

`endif

//--- hw/ssc_pkg.sv
package ssc_pkg;

	typedef enum logic [1:0] {st_in_reset, st_sample, st_hold} ssc_state_e;

	typedef logic [31:0] ssc_word_t;

endpackage

//--- hw/ssc_scl_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssc_consts.svh"

module ssc_scl_divider #(
	parameter int unsigned FAST_HALF = `SSC_HALF_CNT(`SSC_SMB_FAST_KHZ),
	parameter int unsigned SLOW_HALF = `SSC_HALF_CNT(`SSC_SMB_SLOW_KHZ),
	parameter int unsigned CW        = 12
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Control
	input  wire logic run,
	input  wire logic slow,
	// Serial clock level
	output logic      scl
);

	logic [CW-1:0] cnt;
	wire  [CW-1:0] half_m1 = slow ? CW'(SLOW_HALF - 1) : CW'(FAST_HALF - 1);
	wire           at_end  = (cnt == half_m1);

	// The clock idles high so a stopped bus looks free to other masters.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= '0;
			scl <= 1'b1;
		end
		else if (!run)
		begin
			cnt <= '0;
			scl <= 1'b1;
		end
		else if (at_end)
		begin
			cnt <= '0;
			scl <= ~scl;
		end
		else
			cnt <= cnt + 1'b1;
	end

	a_scl_half_period: assert property (@(posedge pclk) disable iff (!presetn)
		(run && $past(run) && $changed(scl)) |-> ($past(cnt) == $past(half_m1)))
		else $error("serial clock edge away from the half period count");

endmodule
`default_nettype wire

//--- hw/ssc_strap_decode.sv
// What this block does
// - Reference strap picks 100 or 125 MHz
// - Slow strap gives 100 kHz, else 400
// - Serial bus speed has no override path
// - EEPROM address bits 4:1 from straps
// - Slave answers only its strapped address
// - Each of 54 pins: GPIO or alternate
// - Merge straps active low, default merged
// - Low strap: even port becomes x8
// - High strap: both ports run as x4
// - Port clock used only in local mode
// - Three-bit strap picks port clocking mode
// - Fundamental reset clears settings and pin function words, not strap flops
`timescale 1ns/1ps
`default_nettype none
`include "ssc_consts.svh"

module ssc_strap_decode
	import ssc_pkg::*;
#(
	parameter logic [6:0] EE_ADDR_BASE   = `SSC_EE_ADDR_BASE,
	parameter logic [6:0] SLV_ADDR_BASE  = `SSC_SLV_ADDR_BASE,
	parameter logic [7:0] LOCAL_MODE_SET = `SSC_LOCAL_MODE_SET
) (
	// APB slave
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [11:0]  paddr,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [31:0]  pwdata,
	input  wire logic [3:0]   pstrb,
	output logic      [31:0]  prdata,
	output logic              pready,
	output logic              pslverr,
	// Chip reset
	input  wire logic         fundamental_reset_n,
	// Configuration straps
	input  wire logic         ref_clock_freq_select,
	input  wire logic         eeprom_bus_slow_strap,
	input  wire logic [3:0]   eeprom_addr_strap,
	input  wire logic [3:0]   slave_mgmt_addr_strap,
	input  wire logic [2:0]   port_clocking_mode_strap,
	input  wire logic         merge_pair0_n,
	input  wire logic         merge_pair1_n,
	input  wire logic         merge_pair2_n,
	input  wire logic         merge_pair3_n,
	input  wire logic         merge_pair4_n,
	input  wire logic         merge_pair5_n,
	input  wire logic         merge_pair6_n,
	input  wire logic         merge_pair7_n,
	// Slave management address check
	input  wire logic [6:0]   slave_rx_addr,
	input  wire logic         slave_rx_addr_valid,
	output logic              slave_addr_hit,
	// Decoded settings
	output logic              cfg_valid,
	output logic              ref_clk_is_125,
	output logic      [7:0]   pll_fb_div,
	output logic              eeprom_bus_slow,
	output logic              eeprom_scl,
	output logic      [6:0]   eeprom_dev_addr,
	output logic      [6:0]   slave_dev_addr,
	output logic      [2:0]   port_clocking_mode,
	output logic      [7:0]   pair_merged,
	output logic      [15:0]  port_enabled,
	output logic      [15:0]  port_local_clk_sel,
	output logic      [63:0]  port_lane_count,
	// Pin function selection
	output logic      [53:0]  gpio_alt_en,
	output logic      [107:0] gpio_alt_sel
);

	function automatic logic mode_is_local(input logic [2:0] mode);
		return LOCAL_MODE_SET[mode];
	endfunction

	function automatic ssc_word_t gpio_word_mask(input logic [2:0] idx);
		int used;
		used = (int'(idx) < `SSC_EN_WORDS)
			? `SSC_GPIO_COUNT - `SSC_WORD_BITS * int'(idx)
			: 2 * `SSC_GPIO_COUNT - `SSC_WORD_BITS * (int'(idx) - `SSC_EN_WORDS);
		if (used >= `SSC_WORD_BITS)
			return '1;
		return 32'((64'd1 << used) - 64'd1);
	endfunction

	function automatic ssc_word_t strobe_merge(input ssc_word_t old_w, input ssc_word_t new_w,
		input logic [3:0] strb);
		ssc_word_t res;
		res = old_w;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				res[b*8 +: 8] = new_w[b*8 +: 8];
		return res;
	endfunction

	// Strap capture and sequencing.
	ssc_state_e state;
	ssc_state_e next_state;
	logic       strap_ref_hi;
	logic       strap_slow;
	logic [3:0] strap_ee;
	logic [3:0] strap_slv;
	logic [2:0] strap_mode;
	logic [7:0] strap_merge_n;

	wire       fund_active = ~fundamental_reset_n;
	wire       capture     = (state == st_in_reset) && fundamental_reset_n;
	wire       do_sample   = (state == st_sample) && fundamental_reset_n;
	wire [7:0] merge_pins_n = {merge_pair7_n, merge_pair6_n, merge_pair5_n, merge_pair4_n,
		merge_pair3_n, merge_pair2_n, merge_pair1_n, merge_pair0_n};

	always_comb
	begin
		next_state = state;
		case (state)
			st_in_reset: next_state = fundamental_reset_n ? st_sample : st_in_reset;
			st_sample:   next_state = fund_active ? st_in_reset : st_hold;
			st_hold:     next_state = fund_active ? st_in_reset : st_hold;
			default:     next_state = st_in_reset;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= st_in_reset;
		else
			state <= next_state;
	end

	// Pins are read once, at the first edge after the chip reset lets go.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			strap_ref_hi  <= 1'b0;
			strap_slow    <= 1'b0;
			strap_ee      <= '0;
			strap_slv     <= '0;
			strap_mode    <= '0;
			strap_merge_n <= '0;
		end
		else if (capture)
		begin
			strap_ref_hi  <= ref_clock_freq_select;
			strap_slow    <= eeprom_bus_slow_strap;
			strap_ee      <= eeprom_addr_strap;
			strap_slv     <= slave_mgmt_addr_strap;
			strap_mode    <= port_clocking_mode_strap;
			strap_merge_n <= merge_pins_n;
		end
	end

	// Per-port decode of merging and clock source.
	logic [7:0]  next_merged;
	logic [15:0] next_enabled;
	logic [15:0] next_local;
	logic [63:0] next_lanes;

	for (genvar g = 0; g < `SSC_PAIRS; g++)
	begin : g_pair
		assign next_merged[g]      = ~strap_merge_n[g];
		assign next_enabled[2*g]   = 1'b1;
		// An absorbed odd port lends its lanes 4..7 to the even port.
		assign next_enabled[2*g+1] = strap_merge_n[g];
		assign next_lanes[(2*g)*`SSC_LANE_BITS +: `SSC_LANE_BITS] =
			strap_merge_n[g] ? `SSC_LANES_X4 : `SSC_LANES_X8;
		assign next_lanes[(2*g+1)*`SSC_LANE_BITS +: `SSC_LANE_BITS] =
			strap_merge_n[g] ? `SSC_LANES_X4 : `SSC_LANES_NONE;
	end

	for (genvar p = 0; p < `SSC_PORTS; p++)
	begin : g_port
		assign next_local[p] = mode_is_local(strap_mode) & next_enabled[p];
	end

	// Settings are zero during chip reset and frozen once valid.
	// The chip reset is a plain synchronous clear, kept apart from the asynchronous one.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_valid          <= 1'b0;
			ref_clk_is_125     <= 1'b0;
			pll_fb_div         <= '0;
			eeprom_bus_slow    <= 1'b0;
			eeprom_dev_addr    <= '0;
			slave_dev_addr     <= '0;
			port_clocking_mode <= '0;
			pair_merged        <= '0;
			port_enabled       <= '0;
			port_local_clk_sel <= '0;
			port_lane_count    <= '0;
		end
		else if (fund_active)
		begin
			cfg_valid          <= 1'b0;
			ref_clk_is_125     <= 1'b0;
			pll_fb_div         <= '0;
			eeprom_bus_slow    <= 1'b0;
			eeprom_dev_addr    <= '0;
			slave_dev_addr     <= '0;
			port_clocking_mode <= '0;
			pair_merged        <= '0;
			port_enabled       <= '0;
			port_local_clk_sel <= '0;
			port_lane_count    <= '0;
		end
		else if (do_sample)
		begin
			cfg_valid          <= 1'b1;
			ref_clk_is_125     <= strap_ref_hi;
			pll_fb_div         <= strap_ref_hi ? `SSC_PLL_DIV_HI : `SSC_PLL_DIV_LO;
			eeprom_bus_slow    <= strap_slow;
			eeprom_dev_addr    <= {EE_ADDR_BASE[6:5], strap_ee, EE_ADDR_BASE[0]};
			slave_dev_addr     <= {SLV_ADDR_BASE[6], strap_slv[3], SLV_ADDR_BASE[4],
				strap_slv[2:0], SLV_ADDR_BASE[0]};
			port_clocking_mode <= strap_mode;
			pair_merged        <= next_merged;
			port_enabled       <= next_enabled;
			port_local_clk_sel <= next_local;
			port_lane_count    <= next_lanes;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			slave_addr_hit <= 1'b0;
		else
			slave_addr_hit <= cfg_valid && slave_rx_addr_valid &&
				(slave_rx_addr == slave_dev_addr);
	end

	// The speed input is wired from the decoded eeprom_bus_slow setting only; no register reaches it.
	ssc_scl_divider u_scl (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (cfg_valid),
		.slow    (eeprom_bus_slow),
		.scl     (eeprom_scl)
	);

	// APB decode, one wait state per transfer.
	ssc_word_t gpio_cfg [`SSC_GPIO_WORDS];

	wire        access    = psel && penable && !pready;
	wire        xfer_done = psel && penable && pready;
	wire        hit_stat  = (paddr == `SSC_OFF_STATUS);
	wire        hit_addrs = (paddr == `SSC_OFF_ADDRS);
	wire        hit_ports = (paddr == `SSC_OFF_PORTS);
	wire        hit_gpio  = (paddr >= `SSC_OFF_GPIO) && (paddr < `SSC_OFF_GPIO_END) &&
		(paddr[1:0] == 2'h0);
	wire [11:0] gpio_off  = paddr - `SSC_OFF_GPIO;
	wire [2:0]  gpio_idx  = gpio_off[4:2];
	wire        mapped    = hit_stat || hit_addrs || hit_ports || hit_gpio;

	ssc_word_t stat_word;
	ssc_word_t addrs_word;
	ssc_word_t ports_word;
	ssc_word_t rd_word;

	always_comb
	begin
		stat_word                            = '0;
		stat_word[`SSC_ST_VALID]             = cfg_valid;
		stat_word[`SSC_ST_REF_HI]            = ref_clk_is_125;
		stat_word[`SSC_ST_SLOW]              = eeprom_bus_slow;
		stat_word[`SSC_ST_MODE +: 3]         = port_clocking_mode;
		stat_word[`SSC_ST_MERGED +: 8]       = pair_merged;
		addrs_word                           = '0;
		addrs_word[`SSC_AD_EE +: 7]          = eeprom_dev_addr;
		addrs_word[`SSC_AD_SLV +: 7]         = slave_dev_addr;
		ports_word                           = '0;
		ports_word[`SSC_PT_LOCAL +: 16]      = port_local_clk_sel;
		ports_word[`SSC_PT_ENABLED +: 16]    = port_enabled;
	end

	assign rd_word = hit_stat  ? stat_word  :
		hit_addrs ? addrs_word :
		hit_ports ? ports_word :
		hit_gpio  ? gpio_cfg[gpio_idx] : 32'h0000_0000;

	// Writes to the decoded settings are dropped without error.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= access;
			pslverr <= access && !mapped;
			if (access)
				prdata <= pwrite ? 32'h0000_0000 : rd_word;
		end
	end

	for (genvar w = 0; w < `SSC_GPIO_WORDS; w++)
	begin : g_gpio
		wire wr_hit = xfer_done && pwrite && hit_gpio && (gpio_idx == 3'(w));

		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				gpio_cfg[w] <= 32'h0000_0000;
			else if (fund_active)
				gpio_cfg[w] <= 32'h0000_0000;
			else if (wr_hit)
				gpio_cfg[w] <= strobe_merge(gpio_cfg[w], pwdata, pstrb) &
					gpio_word_mask(3'(w));
		end
	end

	assign gpio_alt_en  = {gpio_cfg[1][`SSC_EN_TOP_BITS-1:0], gpio_cfg[0]};
	assign gpio_alt_sel = {gpio_cfg[5][`SSC_SEL_TOP_BITS-1:0], gpio_cfg[4], gpio_cfg[3],
		gpio_cfg[2]};

	// Checks.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_release;
		(state == st_in_reset) && fundamental_reset_n;
	endsequence

	sequence s_settled;
		##2 cfg_valid;
	endsequence

	a_ref_pll_div: assert property (
		(do_sample && strap_ref_hi) |=> (ref_clk_is_125 && pll_fb_div == `SSC_PLL_DIV_HI))
		else $error("reference select did not give the high clock divider");

	a_slow_speed_pick: assert property (
		cfg_valid |-> (eeprom_bus_slow == strap_slow))
		else $error("bus speed differs from the strap");

	a_speed_no_override: assert property (
		(cfg_valid && $past(cfg_valid)) |-> $stable(eeprom_bus_slow))
		else $error("bus speed changed while settings were valid");

	a_eeprom_addr_form: assert property (
		cfg_valid |-> (eeprom_dev_addr[4:1] == strap_ee &&
			eeprom_dev_addr[6:5] == EE_ADDR_BASE[6:5]))
		else $error("eeprom address not formed from straps");

	a_slave_addr_only: assert property (
		slave_addr_hit |-> ($past(slave_rx_addr) == slave_dev_addr &&
			slave_dev_addr[5] == strap_slv[3] && slave_dev_addr[3:1] == strap_slv[2:0]))
		else $error("slave hit on a foreign address");

	a_gpio_word_write: assert property (
		(xfer_done && pwrite && hit_gpio && gpio_idx == 3'h0 && pstrb == 4'hF &&
			fundamental_reset_n) |=> (gpio_alt_en[31:0] == $past(pwdata)))
		else $error("pin function word not written");

	a_merge_default_low: assert property (
		(cfg_valid && !strap_merge_n[0]) |-> (pair_merged[0] && !port_enabled[1] &&
			port_lane_count[7:0] == {`SSC_LANES_NONE, `SSC_LANES_X8}))
		else $error("low merge strap did not give an x8 port");

	a_split_x4_pair: assert property (
		(cfg_valid && strap_merge_n[0]) |-> (port_enabled[1] && !pair_merged[0] &&
			port_lane_count[7:0] == {`SSC_LANES_X4, `SSC_LANES_X4}))
		else $error("high merge strap did not give two x4 ports");

	a_local_clock_sel: assert property (
		port_local_clk_sel[1] |-> (port_enabled[1] && mode_is_local(port_clocking_mode)))
		else $error("port clock selected outside local mode");

	a_clock_mode_strap: assert property (
		cfg_valid |-> (port_clocking_mode == strap_mode))
		else $error("clocking mode differs from the strap");

	a_fund_reset_clear: assert property (
		fund_active |=> (!cfg_valid && state == st_in_reset && gpio_alt_en == '0))
		else $error("chip reset did not clear the settings");

	a_strap_sample_hold: assert property (
		(s_release and fundamental_reset_n [*3]) |-> ##1 (strap_mode == $past(port_clocking_mode_strap)) ##0 s_settled)
		else $error("straps not captured at reset release");

endmodule
`default_nettype wire

//--- verif/ssc_strap_board.sv
`timescale 1ns/1ps
`default_nettype none

module ssc_strap_board (
	// Requested board state
	input  wire logic        hold_reset,
	input  wire logic [12:0] level,
	input  wire logic [7:0]  merge_tied_high,
	// Strap pins
	output logic             fundamental_reset_n,
	output logic             ref_clock_freq_select,
	output logic             eeprom_bus_slow_strap,
	output logic [3:0]       eeprom_addr_strap,
	output logic [3:0]       slave_mgmt_addr_strap,
	output logic [2:0]       port_clocking_mode_strap,
	output logic [7:0]       merge_n
);
	assign fundamental_reset_n = !hold_reset;
	assign ref_clock_freq_select = level[0];
	assign eeprom_bus_slow_strap = level[1];
	assign eeprom_addr_strap = level[5:2];
	assign slave_mgmt_addr_strap = level[9:6];
	assign port_clocking_mode_strap = level[12:10];
	// A merge strap with no resistor to the supply reads low through its pull-down.
	assign merge_n = merge_tied_high;
endmodule

`default_nettype wire

//--- verif/switch_strap_config_decode_test.sv
`timescale 1ns/1ps
`default_nettype none

module switch_strap_config_decode_test
	import ssc_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, hold_reset, slave_rx_addr_valid;
	logic [11:0] paddr;
	ssc_word_t pwdata, prdata;
	logic [3:0] pstrb;
	logic [12:0] level, lv;
	logic [7:0] merge_hi, mg, merge_n, pll_fb_div, pair_merged;
	logic [6:0] slave_rx_addr, ee, sv, eeprom_dev_addr, slave_dev_addr;
	logic [15:0] en, loc, port_enabled, port_local_clk_sel;
	logic [63:0] lanes, port_lane_count;
	logic [32:0] exp_q[$];
	logic [32:0] exp_word;
	ssc_word_t d[6];
	wire logic fundamental_reset_n, ref_clock_freq_select, eeprom_bus_slow_strap;
	wire logic [3:0] eeprom_addr_strap, slave_mgmt_addr_strap;
	wire logic [2:0] port_clocking_mode_strap;
	logic slave_addr_hit, cfg_valid, ref_clk_is_125, eeprom_bus_slow, eeprom_scl;
	logic [2:0] port_clocking_mode;
	logic [53:0] gpio_alt_en;
	logic [107:0] gpio_alt_sel;
	int num_errors = 0;
	int compares = 0;

	always #2 pclk = ~pclk;

	ssc_strap_board u_ssc_strap_board (.hold_reset, .level, .merge_tied_high(merge_hi),
		.fundamental_reset_n, .ref_clock_freq_select, .eeprom_bus_slow_strap,
		.eeprom_addr_strap, .slave_mgmt_addr_strap, .port_clocking_mode_strap, .merge_n);

	ssc_strap_decode u_ssc_strap_decode (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .fundamental_reset_n,
		.ref_clock_freq_select, .eeprom_bus_slow_strap, .eeprom_addr_strap,
		.slave_mgmt_addr_strap, .port_clocking_mode_strap,
		.merge_pair0_n(merge_n[0]), .merge_pair1_n(merge_n[1]), .merge_pair2_n(merge_n[2]),
		.merge_pair3_n(merge_n[3]), .merge_pair4_n(merge_n[4]), .merge_pair5_n(merge_n[5]),
		.merge_pair6_n(merge_n[6]), .merge_pair7_n(merge_n[7]), .slave_rx_addr,
		.slave_rx_addr_valid, .slave_addr_hit, .cfg_valid, .ref_clk_is_125, .pll_fb_div,
		.eeprom_bus_slow, .eeprom_scl, .eeprom_dev_addr, .slave_dev_addr,
		.port_clocking_mode, .pair_merged, .port_enabled, .port_local_clk_sel,
		.port_lane_count, .gpio_alt_en, .gpio_alt_sel);

	task summarize;
		$display("Counts: %0d compares, %0d mismatches", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task check(input logic [127:0] got, input logic [127:0] exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t setting %0h expected %0h", $time, got, exp);
		end
	endtask

	// Bus answers are compared in the order the requests were issued.
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1)
		begin
			compares++;
			exp_word = exp_q.pop_front();
			if ({pslverr, prdata} !== exp_word)
			begin
				num_errors++;
				$display("BAD %0t bus answer %0h expected %0h", $time, {pslverr, prdata}, exp_word);
			end
		end

	// One idle cycle follows each transfer so no signal is driven twice in a time step.
	task apb(input logic wr, input logic [11:0] a, input ssc_word_t dat, input logic [32:0] exp);
		exp_q.push_back(exp);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dat;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task predict;
		lv = level;
		mg = ~merge_hi;
		for (int i = 0; i < 8; i++)
		begin
			en[2*i] = 1'b1;
			en[2*i+1] = merge_hi[i];
			lanes[8*i +: 8] = merge_hi[i] ? 8'h44 : 8'h08;
		end
		loc = (lv[12:10] >= 3'h4) ? en : 16'h0000;
		ee = {2'b10, lv[5:2], 1'b0};
		sv = {1'b1, lv[9], 1'b0, lv[8:6], 1'b0};
	endtask

	task check_cfg;
		check(ref_clk_is_125, lv[0]);
		check(pll_fb_div, lv[0] ? 8'h14 : 8'h19);
		check(eeprom_bus_slow, lv[1]);
		check(eeprom_dev_addr, ee);
		check(slave_dev_addr, sv);
		check(port_clocking_mode, lv[12:10]);
		check(pair_merged, mg);
		check(port_lane_count, lanes);
		check(port_enabled, en);
		check(port_local_clk_sel, loc);
		check(cfg_valid, 1'b1);
	endtask

	task hit(input logic [6:0] a, input logic exp);
		slave_rx_addr <= a;
		slave_rx_addr_valid <= 1'b1;
		@(posedge pclk);
		slave_rx_addr_valid <= 1'b0;
		@(posedge pclk);
		check(slave_addr_hit, exp);
	endtask

	task run_cfg(input logic [2:0] mode);
		int n;
		logic s;
		hold_reset <= 1'b1;
		level <= {mode, 10'($urandom)};
		merge_hi <= 8'($urandom);
		// The serial clock returns high one edge after the settings clear.
		repeat (3) @(posedge pclk);
		check({cfg_valid, pair_merged, eeprom_scl}, 10'h001);
		hold_reset <= 1'b0;
		n = 0;
		do @(posedge pclk); while (cfg_valid !== 1'b1 && ++n < 10);
		predict;
		check_cfg;
		apb(1'b0, 12'h000, 32'h0, {17'h0, mg, 1'b0, mode, 1'b0, lv[1:0], 1'b1});
		apb(1'b1, 12'h000, 32'hFFFF_FFFF, 33'h0);
		apb(1'b0, 12'h000, 32'h0, {17'h0, mg, 1'b0, mode, 1'b0, lv[1:0], 1'b1});
		apb(1'b0, 12'h004, 32'h0, {18'h0, sv, 1'b0, ee});
		apb(1'b0, 12'h008, 32'h0, {1'b0, en, loc});
		hit(sv, 1'b1);
		hit(sv ^ (mode[0] ? 7'h20 : 7'h02 << mode[2:1]), 1'b0);
		for (int k = 0; k < 2; k++)
		begin
			n = 0;
			s = eeprom_scl;
			while (eeprom_scl === s && n < 3000)
			begin
				@(posedge pclk);
				n++;
			end
		end
		check(n, lv[1] ? 16'h04E2 : 16'h0139);
		level <= ~level;
		merge_hi <= ~merge_hi;
		repeat (3) @(posedge pclk);
		check_cfg;
		$display("test clock mode %0d done", mode);
	endtask

	initial
	begin
		// Eight modes of at most about 2600 cycles each, with a wide margin.
		#200000;
		num_errors++;
		summarize;
	end

	initial
	begin
		{presetn, psel, penable, pwrite, slave_rx_addr_valid} = 5'h00;
		{paddr, pwdata, slave_rx_addr, level, merge_hi} = '0;
		pstrb = 4'hF;
		hold_reset = 1'b1;
		void'($urandom(59));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int m = 0; m < 8; m++)
			run_cfg(3'(m));
		for (int w = 0; w < 6; w++)
		begin
			d[w] = $urandom;
			apb(1'b1, 12'h010 + 12'(4 * w), d[w], 33'h0);
		end
		d[1][31:22] = '0;
		d[5][31:12] = '0;
		for (int w = 0; w < 6; w++)
			apb(1'b0, 12'h010 + 12'(4 * w), 32'h0, {1'b0, d[w]});
		check(gpio_alt_en, {d[1][21:0], d[0]});
		check(gpio_alt_sel, {d[5][11:0], d[4], d[3], d[2]});
		apb(1'b0, 12'h00C, 32'h0, {1'b1, 32'h0});
		apb(1'b1, 12'h028, 32'h1234_5678, {1'b1, 32'h0});
		$display("test pin functions done");
		summarize;
	end
endmodule

`default_nettype wire
